// ==== rtl/pbc_ctrl.v ====
// Basic control register of the 10/100 transceiver with its data path steering
`timescale 1ns/10ps
`default_nettype none

// Function
// - Writing one to the reset bit restores every default; the bit clears itself.
// - Loopback on routes transmit nibbles back onto the receive data lines.
// - Loopback sends nothing to the line and ignores line receive data.
// - Speed bit picks 100 Mb/s when one, 10 Mb/s when zero, without negotiation.
// - With negotiation enabled, speed and duplex writes are ignored and have no effect.
// - Duplex bit picks full duplex when one, half when zero, without negotiation.
// - Speed, duplex and negotiation enable reset to one; all other bits to zero.
// - The negotiation enable bit turns the negotiation process on.
// - Negotiation disabled: link speed and duplex come straight from the register bits.
// - The power-down bit puts the transceiver into its low-power state.
// - Management reads and writes are still answered while powered down.
// - Negotiation starts by itself after power-up.
// - Writing one to the restart bit restarts negotiation while negotiation is enabled; the bit clears itself.
// - Collision test on asserts the collision output whenever transmit enable is high.
// - Collision test is suppressed while the coding bypass bit is high.
// - Collision test works in full duplex and in half duplex alike.
// - Answers transceiver address 00001b; this register sits at register address zero.

`include "pbc_map.vh"

module pbc_ctrl #(
    parameter NIBBLE_W = 4
) (
    input  wire                i_ref_clk,         // Device clock, 125 MHz
    input  wire                i_rst,             // Asynchronous reset, active high
    // Management transaction port
    input  wire                i_mgmt_req,        // Transaction request, one-cycle pulse
    input  wire                i_mgmt_write,      // 1 write, 0 read
    input  wire [4:0]          i_mgmt_phy_addr,   // Transceiver address of the transaction
    input  wire [4:0]          i_mgmt_reg_addr,   // Register address of the transaction
    input  wire [15:0]         i_mgmt_wdata,      // Write data
    output reg                 o_mgmt_ack,        // Answer, one-cycle pulse
    output reg                 o_mgmt_hit,        // Answer came from this transceiver
    output reg  [15:0]         o_mgmt_rdata,      // Read data, valid with the answer
    // Vendor register bit and negotiation results
    input  wire                i_coding_bypass,   // Coding bypass bit of vendor register
    input  wire                i_an_speed_100,    // Negotiated speed, 1 = 100 Mb/s
    input  wire                i_an_full_duplex,  // Negotiated duplex, 1 = full
    // MAC-side nibble interface
    input  wire [NIBBLE_W-1:0] i_txd,             // Transmit nibble from the MAC
    input  wire                i_tx_en,           // Transmit enable from the MAC
    output reg  [NIBBLE_W-1:0] o_rxd,             // Receive nibble to the MAC
    output reg                 o_rx_dv,           // Receive data valid to the MAC
    output reg                 o_col,             // Collision indication to the MAC
    // Line-side data path
    output reg  [NIBBLE_W-1:0] o_line_txd,        // Nibble toward the line coder
    output reg                 o_line_tx_en,      // Transmit enable toward the line
    input  wire [NIBBLE_W-1:0] i_line_rxd,        // Nibble from the line decoder
    input  wire                i_line_rx_dv,      // Receive valid from the line
    input  wire                i_line_col,        // Collision seen on the line
    // Control outputs to the rest of the transceiver
    output reg                 o_soft_reset,      // Software reset pulse
    output wire                o_an_enable,       // Negotiation enable level
    output reg                 o_an_restart,      // Negotiation (re)start pulse
    output wire                o_power_down,      // Low-power state request
    output wire                o_speed_100,       // Operating speed, 1 = 100 Mb/s
    output wire                o_full_duplex,     // Operating duplex, 1 = full
    output wire                o_loopback         // Loopback active
);

    ////////////////////////////////////////////////////////////////////////////
    // Read value of the register from its stored bits

    function [15:0] pbc_pack;
        input lb;
        input spd;
        input ane;
        input pd;
        input dpx;
        input collision_test;
        reg [15:0] v;
        begin
            v = 16'h0000;
            v[`PBC_BIT_LOOPBACK]   = lb;
            v[`PBC_BIT_SPEED]      = spd;
            v[`PBC_BIT_AN_ENABLE]  = ane;
            v[`PBC_BIT_POWER_DOWN] = pd;
            v[`PBC_BIT_DUPLEX]     = dpx;
            v[`PBC_BIT_COL_TEST]   = collision_test;
            pbc_pack = v;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Line-side inputs cross in through two flip-flops

    localparam LINE_W = NIBBLE_W + 2;
    localparam [15:0] CTRL_RST = `PBC_CTRL_RESET_VAL;

    wire [LINE_W-1:0] line_sync;
    wire [NIBBLE_W-1:0] line_rxd_s;
    wire              line_rx_dv_s;
    wire              line_col_s;

    pbc_sync #(
        .WIDTH (LINE_W)
    ) u_line_sync (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_async   ({i_line_col, i_line_rx_dv, i_line_rxd}),
        .o_sync    (line_sync)
    );

    assign line_rxd_s   = line_sync[NIBBLE_W-1:0];
    assign line_rx_dv_s = line_sync[NIBBLE_W];
    assign line_col_s   = line_sync[NIBBLE_W+1];

    ////////////////////////////////////////////////////////////////////////////
    // Transaction decode

    wire for_me;
    wire ctrl_sel;
    wire ctrl_wr;

    assign for_me   = i_mgmt_req && (i_mgmt_phy_addr == `PBC_PHY_ADDR);
    assign ctrl_sel = for_me && (i_mgmt_reg_addr == `PBC_CTRL_REG_ADDR);
    // Power-down gates nothing here, so transactions stay live
    assign ctrl_wr  = ctrl_sel && i_mgmt_write;

    ////////////////////////////////////////////////////////////////////////////
    // Stored control bits

    reg  loopback_q;
    reg  speed_q;
    reg  an_enable_q;
    reg  power_down_q;
    reg  duplex_q;
    reg  col_test_q;
    wire soft_reset_wr;
    wire restart_wr;

    assign soft_reset_wr = ctrl_wr && i_mgmt_wdata[`PBC_BIT_SOFT_RESET];
    assign restart_wr    = ctrl_wr && i_mgmt_wdata[`PBC_BIT_AN_RESTART];

    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            loopback_q   <= CTRL_RST[`PBC_BIT_LOOPBACK];
            speed_q      <= CTRL_RST[`PBC_BIT_SPEED];
            an_enable_q  <= CTRL_RST[`PBC_BIT_AN_ENABLE];
            power_down_q <= CTRL_RST[`PBC_BIT_POWER_DOWN];
            duplex_q     <= CTRL_RST[`PBC_BIT_DUPLEX];
            col_test_q   <= CTRL_RST[`PBC_BIT_COL_TEST];
        end else if (soft_reset_wr) begin
            // Reset wins over every other bit of the same write
            loopback_q   <= CTRL_RST[`PBC_BIT_LOOPBACK];
            speed_q      <= CTRL_RST[`PBC_BIT_SPEED];
            an_enable_q  <= CTRL_RST[`PBC_BIT_AN_ENABLE];
            power_down_q <= CTRL_RST[`PBC_BIT_POWER_DOWN];
            duplex_q     <= CTRL_RST[`PBC_BIT_DUPLEX];
            col_test_q   <= CTRL_RST[`PBC_BIT_COL_TEST];
        end else if (ctrl_wr) begin
            loopback_q   <= i_mgmt_wdata[`PBC_BIT_LOOPBACK];
            an_enable_q  <= i_mgmt_wdata[`PBC_BIT_AN_ENABLE];
            power_down_q <= i_mgmt_wdata[`PBC_BIT_POWER_DOWN];
            col_test_q   <= i_mgmt_wdata[`PBC_BIT_COL_TEST];
            // Lock is judged by the enable as it stood before this write
            if (!an_enable_q) begin
                speed_q  <= i_mgmt_wdata[`PBC_BIT_SPEED];
                duplex_q <= i_mgmt_wdata[`PBC_BIT_DUPLEX];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Self-clearing pulses: reset, and negotiation start

    reg boot_q;

    // Reset and restart bits are never stored, so they read back as zero
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            boot_q       <= 1'b1;
            o_soft_reset <= 1'b0;
            o_an_restart <= 1'b0;
        end else begin
            boot_q       <= 1'b0;
            o_soft_reset <= soft_reset_wr;
            // A reset restores the enable, so negotiation starts again after it
            o_an_restart <= boot_q
                         || soft_reset_wr
                         || (restart_wr && an_enable_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Management answer, one cycle after the request

    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_mgmt_ack   <= 1'b0;
            o_mgmt_hit   <= 1'b0;
            o_mgmt_rdata <= 16'h0000;
        end else begin
            o_mgmt_ack <= i_mgmt_req;
            o_mgmt_hit <= for_me;
            if (!i_mgmt_req) begin
                o_mgmt_rdata <= o_mgmt_rdata;
            end else if (!for_me) begin
                // Nobody drives the data line for a foreign address
                o_mgmt_rdata <= `PBC_NO_PHY_RDATA;
            end else if (ctrl_sel && !i_mgmt_write) begin
                o_mgmt_rdata <= pbc_pack(loopback_q, speed_q, an_enable_q,
                                         power_down_q, duplex_q, col_test_q);
            end else begin
                o_mgmt_rdata <= `PBC_UNSUP_RDATA;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Operating mode

    assign o_an_enable   = an_enable_q;
    assign o_power_down  = power_down_q;
    assign o_loopback    = loopback_q;
    // Forced bits are ignored while negotiation decides
    assign o_speed_100   = an_enable_q ? i_an_speed_100 : speed_q;
    assign o_full_duplex = an_enable_q ? i_an_full_duplex : duplex_q;

    ////////////////////////////////////////////////////////////////////////////
    // Data path steering

    wire col_test_on;
    wire line_live;

    // Duplex plays no part in the test collision
    assign col_test_on = col_test_q && !i_coding_bypass;
    assign line_live   = !loopback_q && !power_down_q;

    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rxd        <= {NIBBLE_W{1'b0}};
            o_rx_dv      <= 1'b0;
            o_col        <= 1'b0;
            o_line_txd   <= {NIBBLE_W{1'b0}};
            o_line_tx_en <= 1'b0;
        end else begin
            if (loopback_q) begin
                o_rxd   <= i_txd;
                o_rx_dv <= i_tx_en;
            end else if (line_live) begin
                o_rxd   <= line_rxd_s;
                o_rx_dv <= line_rx_dv_s;
            end else begin
                o_rxd   <= {NIBBLE_W{1'b0}};
                o_rx_dv <= 1'b0;
            end
            if (line_live) begin
                o_line_txd   <= i_txd;
                o_line_tx_en <= i_tx_en;
            end else begin
                o_line_txd   <= {NIBBLE_W{1'b0}};
                o_line_tx_en <= 1'b0;
            end
            // Line collisions only matter in half duplex and never in loopback
            o_col <= (col_test_on && i_tx_en)
                  || (line_live && !o_full_duplex && line_col_s);
        end
    end

endmodule // pbc_ctrl

`default_nettype wire

// ==== rtl/pbc_map.vh ====
// Field positions, addresses and reset values of the transceiver control register
`ifndef PBC_MAP_VH
`define PBC_MAP_VH

`define PBC_PHY_ADDR        5'h01
`define PBC_CTRL_REG_ADDR   5'h00

`define PBC_BIT_SOFT_RESET  15
`define PBC_BIT_LOOPBACK    14
`define PBC_BIT_SPEED       13
`define PBC_BIT_AN_ENABLE   12
`define PBC_BIT_POWER_DOWN  11
`define PBC_BIT_AN_RESTART  9
`define PBC_BIT_DUPLEX      8
`define PBC_BIT_COL_TEST    7

`define PBC_CTRL_RESET_VAL  16'h3100
`define PBC_NO_PHY_RDATA    16'hffff
`define PBC_UNSUP_RDATA     16'h0000

`define PBC_SYNC_STAGES     2

`endif

// ==== rtl/pbc_sync.v ====
// Two-stage synchroniser for level signals arriving from the line side
`timescale 1ns/10ps
`default_nettype none

module pbc_sync #(
    parameter WIDTH = 1
) (
    input  wire             i_ref_clk,   // Device clock
    input  wire             i_rst,       // Asynchronous reset, active high
    input  wire [WIDTH-1:0] i_async,     // Signals from outside the clock domain
    output wire [WIDTH-1:0] o_sync       // Signals after two flip-flops
);

    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    // The first stage feeds only the second stage
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;

endmodule // pbc_sync

`default_nettype wire

// ==== tb/pbc_ctrl_sva.sv ====
// Assertion checker on the control register ports
`timescale 1ns/10ps
`default_nettype none
module pbc_ctrl_sva #(parameter NIBBLE_W = 4) (
    input wire logic        i_ref_clk, i_rst, i_mgmt_req, i_mgmt_write, o_mgmt_ack, o_mgmt_hit,
    input wire logic [4:0]  i_mgmt_phy_addr, i_mgmt_reg_addr,
    input wire logic [15:0] i_mgmt_wdata, o_mgmt_rdata,
    input wire logic        i_coding_bypass, i_an_speed_100, i_an_full_duplex, i_tx_en, o_rx_dv,
    input wire logic        o_col, o_line_tx_en, o_soft_reset, o_an_enable, o_an_restart,
    input wire logic        o_power_down, o_loopback, o_speed_100, o_full_duplex,
    input wire logic [NIBBLE_W-1:0] i_txd, o_rxd
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    wire own = i_mgmt_req && i_mgmt_phy_addr == 5'h01 && i_mgmt_reg_addr == 5'h00;
    logic collision_test_q;
    // Shadow of the collision test bit, which is not visible at the ports
    always_ff @(posedge i_ref_clk or posedge i_rst)
        if (i_rst) collision_test_q <= 1'b0;
        else if (own && i_mgmt_write) collision_test_q <= i_mgmt_wdata[7] & ~i_mgmt_wdata[15];
    property p_ack; o_mgmt_ack == $past(i_mgmt_req); endproperty
    a_ack: assert property (p_ack) else $error("answer without request");
    property p_hit; i_mgmt_req |=> o_mgmt_hit == ($past(i_mgmt_phy_addr) == 5'h01); endproperty
    a_hit: assert property (p_hit) else $error("address match wrong");
    property p_sreset; own && i_mgmt_write && i_mgmt_wdata[15] |=> o_soft_reset && o_an_restart
        && o_an_enable && !o_loopback && !o_power_down; endproperty
    a_sreset: assert property (p_sreset) else $error("soft reset missed");
    property p_rdctl; own && !i_mgmt_write |=> {o_mgmt_rdata[15:9], o_mgmt_rdata[6:0]} ==
        {1'b0, o_loopback, o_mgmt_rdata[13], o_an_enable, o_power_down, 9'h000}; endproperty
    a_rdctl: assert property (p_rdctl) else $error("read value wrong");
    property p_restart; own && i_mgmt_write && i_mgmt_wdata[9] && o_an_enable |=> o_an_restart;
    endproperty
    a_restart: assert property (p_restart) else $error("restart missed");
    property p_an; o_an_enable |-> o_speed_100 == i_an_speed_100
        && o_full_duplex == i_an_full_duplex; endproperty
    a_an: assert property (p_an) else $error("forced mode leaks");
    property p_loop; o_loopback && $past(o_loopback) |-> o_rxd == $past(i_txd)
        && o_rx_dv == $past(i_tx_en) && !o_line_tx_en; endproperty
    a_loop: assert property (p_loop) else $error("loopback path wrong");
    property p_col; collision_test_q && !i_coding_bypass && i_tx_en |=> o_col; endproperty
    a_col: assert property (p_col) else $error("collision test missed");
    c_sreset: cover property (own && i_mgmt_write && i_mgmt_wdata[15]);
    c_loop: cover property (o_loopback && i_tx_en);
    c_col: cover property (o_col && collision_test_q);
endmodule // pbc_ctrl_sva
bind pbc_ctrl pbc_ctrl_sva #(.NIBBLE_W(NIBBLE_W)) sva_u (.*);
`default_nettype wire

// ==== tb/pbc_mac_model.sv ====
// Station management model of the MAC side
`timescale 1ns/10ps
`default_nettype none
module pbc_mac_model (
    input  wire logic        i_ref_clk,       // Device clock
    input  wire logic        i_mgmt_ack,      // Answer pulse
    input  wire logic        i_mgmt_hit,      // Own-address flag
    input  wire logic [15:0] i_mgmt_rdata,    // Read data
    output var  logic        o_mgmt_req,      // Request pulse
    output var  logic        o_mgmt_write,    // 1 write, 0 read
    output var  logic [4:0]  o_mgmt_phy_addr, // Transceiver address
    output var  logic [4:0]  o_mgmt_reg_addr, // Register address
    output var  logic [15:0] o_mgmt_wdata     // Write data
);
    initial {o_mgmt_req, o_mgmt_write, o_mgmt_phy_addr, o_mgmt_reg_addr, o_mgmt_wdata} = 28'h0;
    task automatic xfer(input logic w, input logic [4:0] p, r, input logic [15:0] d,
                        output logic [15:0] rd, output logic hit, output logic ok);
        ok = 1'b0;
        @(negedge i_ref_clk);
        {o_mgmt_req, o_mgmt_write, o_mgmt_phy_addr, o_mgmt_reg_addr, o_mgmt_wdata} =
            {1'b1, w, p, r, d};
        // The answer stands one cycle, so look right after each edge
        for (int i = 0; i < 4 && !ok; i++) begin
            @(posedge i_ref_clk);
            #1;
            {hit, rd} = {i_mgmt_hit, i_mgmt_rdata};
            ok = i_mgmt_ack === 1'b1;
        end
        @(negedge i_ref_clk);
        // Qualifiers count only with the request, so scramble them afterwards
        {o_mgmt_req, o_mgmt_write, o_mgmt_phy_addr, o_mgmt_reg_addr, o_mgmt_wdata} =
            {1'b0, ~w, ~p, ~r, ~d};
    endtask
endmodule // pbc_mac_model
`default_nettype wire

// ==== tb/tb_pbc_ctrl.sv ====
// Self-checking bench of the transceiver control register
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
    $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module tb_pbc_ctrl;
    logic        i_ref_clk = 1'b0, i_rst = 1'b1, i_mgmt_req, i_mgmt_write, o_mgmt_ack, o_mgmt_hit;
    logic [4:0]  i_mgmt_phy_addr, i_mgmt_reg_addr;
    logic [15:0] i_mgmt_wdata, o_mgmt_rdata, rd, m_ctl;
    logic        i_coding_bypass, i_an_speed_100, i_an_full_duplex, i_tx_en, o_rx_dv, o_col;
    logic        o_line_tx_en, i_line_rx_dv, i_line_col, o_soft_reset, o_an_enable, o_an_restart;
    logic        o_power_down, o_speed_100, o_full_duplex, o_loopback, h, ok, pen;
    logic [3:0]  i_txd, o_rxd, o_line_txd, i_line_rxd, ptxd;
    int          n_errors = 0, cmp_count = 0, n_rst = 0, n_srst = 0;

    always #4 i_ref_clk = ~i_ref_clk;
    // Pulse counters, so a one-cycle output is never missed between checks
    always @(posedge i_ref_clk) begin
        n_rst <= n_rst + int'(o_an_restart);
        n_srst <= n_srst + int'(o_soft_reset);
    end
    pbc_ctrl #(.NIBBLE_W(4)) dut_u (.*);
    pbc_mac_model mac_u (.i_ref_clk(i_ref_clk), .i_mgmt_ack(o_mgmt_ack), .i_mgmt_hit(o_mgmt_hit),
        .i_mgmt_rdata(o_mgmt_rdata), .o_mgmt_req(i_mgmt_req), .o_mgmt_write(i_mgmt_write),
        .o_mgmt_phy_addr(i_mgmt_phy_addr), .o_mgmt_reg_addr(i_mgmt_reg_addr),
        .o_mgmt_wdata(i_mgmt_wdata));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] upd(input logic [15:0] old, input logic [15:0] d);
        if (d[15]) return 16'h3100;
        return (d & 16'h5880) | (old[12] ? old & 16'h2100 : d & 16'h2100);
    endfunction
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic acc(input logic w, input logic [4:0] p, r, input logic [15:0] d);
        mac_u.xfer(w, p, r, d, rd, h, ok);
        if (!ok) begin
            n_errors++;
            complete_run();
        end else `CHK(h, p == 5'h01)
    endtask
    task automatic rd0();
        acc(1'b0, 5'h01, 5'h00, 16'h0000);
        `CHK(o_mgmt_rdata, m_ctl)
        `CHK(o_an_enable, m_ctl[12])
        `CHK(o_speed_100, m_ctl[12] ? i_an_speed_100 : m_ctl[13])
        `CHK(o_full_duplex, m_ctl[12] ? i_an_full_duplex : m_ctl[8])
        `CHK({o_loopback, o_power_down}, {m_ctl[14], m_ctl[11]})
    endtask
    task automatic wr0(input logic [15:0] d);
        int r0, s0;
        r0 = n_rst;
        s0 = n_srst;
        acc(1'b1, 5'h01, 5'h00, d);
        // Pulse counters pick up the answer-cycle pulses one edge later
        @(posedge i_ref_clk);
        #1;
        `CHK(n_srst - s0, int'(d[15]))
        `CHK(n_rst - r0, int'(d[15] | (d[9] & m_ctl[12])))
        m_ctl = upd(m_ctl, d);
        rd0();
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge i_ref_clk);
        n_errors++;
        complete_run();
    end
    initial begin
        {i_coding_bypass, i_an_speed_100, i_an_full_duplex, i_tx_en, i_line_rx_dv} = 5'h02;
        {i_line_col, i_txd, i_line_rxd} = 9'h000;
        m_ctl = 16'h3100;
        void'($urandom(1));
        repeat (4) @(posedge i_ref_clk);
        @(negedge i_ref_clk);
        i_rst = 1'b0;
        repeat (2) @(negedge i_ref_clk);
        `CHK(n_rst, 1)
        rd0();
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            @(negedge i_ref_clk);
            {i_an_speed_100, i_an_full_duplex} = 2'($urandom);
            wr0(16'($urandom) & 16'h7fff | 16'h1000);
        end
        $display("test negotiation lock done");
        for (int i = 0; i < 8; i++)
            wr0(16'(i[0]) << 13 | 16'(i[1]) << 8 | 16'(i[2]) << 9);
        $display("test forced mode done");
        acc(1'b0, 5'h02, 5'h00, 16'h0000);
        `CHK(o_mgmt_rdata, 16'hffff)
        acc(1'b1, 5'h02, 5'h00, 16'h4880);
        acc(1'b0, 5'h01, 5'h05, 16'h0000);
        `CHK(o_mgmt_rdata, 16'h0000)
        rd0();
        $display("test address decode done");
        wr0(16'h4000);
        {ptxd, pen} = {i_txd, i_tx_en};
        for (int i = 0; i < 10; i++) begin
            @(negedge i_ref_clk);
            `CHK({o_rxd, o_rx_dv, o_line_tx_en}, {ptxd, pen, 1'b0})
            {i_txd, i_tx_en, i_line_rxd, i_line_rx_dv} = 10'($urandom);
            {ptxd, pen} = {i_txd, i_tx_en};
        end
        $display("test loopback done");
        for (int i = 0; i < 4; i++) begin
            @(negedge i_ref_clk);
            {i_coding_bypass, i_tx_en} = {i[1], 1'b0};
            wr0(16'h0080 | 16'(i[0]) << 8);
            @(negedge i_ref_clk);
            i_tx_en = 1'b1;
            @(negedge i_ref_clk);
            `CHK(o_col, ~i_coding_bypass)
        end
        $display("test collision done");
        wr0(16'h0800);
        repeat (2) @(negedge i_ref_clk);
        `CHK(o_line_tx_en, 1'b0)
        wr0(16'h0000);
        @(negedge i_ref_clk);
        `CHK(o_line_tx_en, 1'b1)
        $display("test power down done");
        wr0(16'hc880);
        $display("test soft reset done");
        complete_run();
    end
endmodule // tb_pbc_ctrl
`default_nettype wire
